//--- design/fls_pkg.sv
// package for the flash lock/fuse self-access sequencer
// assumes a 100 MHz cpu clock; shared by the sequencer and its timer
package fls_pkg;
   // control register bit positions
   localparam int BIT_IRQ_EN   = 7;
   localparam int BIT_RWW_BUSY = 6;
   localparam int BIT_RWW_RE   = 4;
   localparam int BIT_LOCK_SET = 3;
   localparam int BIT_PG_WRITE = 2;
   localparam int BIT_PG_ERASE = 1;
   localparam int BIT_STORE_EN = 0;
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] CMD_MASK     = 8'h1f;
   localparam logic [7:0] CMD_LOCK_WR  = 8'h09;
   localparam logic [7:0] CMD_RWW_RE   = 8'h11;
   localparam logic [7:0] CMD_PG_ERASE = 8'h03;
   localparam logic [7:0] CMD_PG_WRITE = 8'h05;
   localparam logic [7:0] CMD_PG_LOAD  = 8'h01;
   // pointer values for fuse and lock reads
   localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
   localparam logic [15:0] PTR_LOCK      = 16'h0001;
   localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
   localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;
   // command windows in cycles
   localparam logic [2:0] STORE_WINDOW = 3'h4;
   localparam logic [2:0] LOAD_WINDOW  = 3'h3;
   // lock byte layout
   localparam int LOCK_BITS = 6;
   localparam int EXT_BITS  = 3;
   localparam logic [7:0] LOCK_RESET = 8'hff;
   // write time, rounded so 3.7 ms min and 4.5 ms max both hold
   localparam int CLK_MHZ      = 100;
   localparam int WRITE_TIME_US = 4000;
   localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_BUSY  = 2'b10
   } fls_state_e;
endpackage

//--- design/fls_timer.sv
// oscillator-timed write duration counter
// assumes start is a one-cycle pulse on mclk
`timescale 1ns/10ps
`default_nettype none
module fls_timer #(
   parameter int CYCLES = fls_pkg::WRITE_CYCLES
) (
   // clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // control
   input  wire logic start,
   output logic      done
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   logic        run_q;
   logic        last;
   assign last  = run_q && (cnt_q == 32'(CYCLES - 1));
   assign cnt_d = start ? 32'h0 : (run_q ? cnt_q + 32'h1 : cnt_q);
   assign done  = last;
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 32'h0;
         run_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         run_q <= start | (run_q & ~last);
      end
   end
endmodule
`default_nettype wire

//--- design/fls_seq.sv
// lock-bit write and fuse/lock read sequencer for self-programming
// assumes cpu strobes store/load instructions on mclk; eeprom busy is a pin
`timescale 1ns/10ps
`default_nettype none
module fls_seq #(
   parameter int WRITE_CYCLES = fls_pkg::WRITE_CYCLES
) (
   // clock and resets; cpu_rst is the core reset that must not abort writes
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        cpu_rst,
   // control register access
   input  wire logic        ctrl_wr,
   input  wire logic [7:0]  ctrl_wdata,
   output logic      [7:0]  ctrl_rdata,
   // cpu instructions
   input  wire logic        store_strobe,
   input  wire logic        load_strobe,
   input  wire logic [15:0] pointer,
   input  wire logic [7:0]  r0_data,
   input  wire logic        rww_target,
   output logic      [7:0]  load_data,
   output logic             load_is_special,
   // nonvolatile contents
   input  wire logic        eeprom_write_busy,
   input  wire logic [7:0]  fuse_low_byte,
   input  wire logic [7:0]  fuse_high_byte,
   input  wire logic [2:0]  fuse_extended_byte,
   // status
   output logic [7:0]       lock_bits,
   output logic             rww_read_blocked,
   output logic             cpu_halt
);
   logic [7:0] ctrl_q;
   logic [7:0] lock_q;
   logic [2:0] win_q;
   logic       busy_q;
   logic       page_q;
   logic [7:0] ld_q;
   logic       ldsp_q;
   logic       ee_s1_q;
   logic       ee_q;
   fls_pkg::fls_state_e st_q;
   fls_pkg::fls_state_e st_d;

   // eeprom busy synchroniser
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         ee_s1_q <= 1'b0;
         ee_q    <= 1'b0;
      end else begin
         ee_s1_q <= eeprom_write_busy;
         ee_q    <= ee_s1_q;
      end
   end

   wire        armed    = (st_q == fls_pkg::ST_ARMED);
   wire        busy     = (st_q == fls_pkg::ST_BUSY);
   wire [7:0]  cmd      = ctrl_q & fls_pkg::CMD_MASK;
   wire        lock_rd  = armed && (cmd == fls_pkg::CMD_LOCK_WR)
                          && (win_q < fls_pkg::LOAD_WINDOW);
   wire        do_load  = load_strobe && lock_rd && !ee_q;
   wire        do_store = store_strobe && armed && !ee_q;
   wire        lock_wr  = do_store && (cmd == fls_pkg::CMD_LOCK_WR);
   wire        pg_op    = do_store && ((cmd == fls_pkg::CMD_PG_ERASE)
                          || (cmd == fls_pkg::CMD_PG_WRITE));
   wire        rww_re   = do_store && (cmd == fls_pkg::CMD_RWW_RE);
   wire        pg_load  = do_store && (cmd == fls_pkg::CMD_PG_LOAD);
   wire        win_out  = armed && (win_q >= fls_pkg::STORE_WINDOW - 3'h1);
   wire        wr_arm   = ctrl_wr && ctrl_wdata[fls_pkg::BIT_STORE_EN]
                          && !busy && !ee_q;
   wire        done;
   wire        start    = lock_wr || pg_op;

   // pointer-selected fuse/lock byte, programmed reads zero
   function automatic logic [7:0] fls_sel(input logic [15:0] p, input logic [7:0] lk,
                                          input logic [7:0] fl, input logic [7:0] fh,
                                          input logic [2:0] fe);
      case (p)
         fls_pkg::PTR_LOCK:      fls_sel = lk;
         fls_pkg::PTR_FUSE_LOW:  fls_sel = fl;
         fls_pkg::PTR_FUSE_HIGH: fls_sel = fh;
         fls_pkg::PTR_FUSE_EXT:  fls_sel = {5'h1f, fe};
         default:                fls_sel = lk;
      endcase
   endfunction

   always_comb begin
      st_d = st_q;
      case (st_q)
         fls_pkg::ST_IDLE:  if (wr_arm) st_d = fls_pkg::ST_ARMED;
         fls_pkg::ST_ARMED: begin
            if (start) st_d = fls_pkg::ST_BUSY;
            else if (do_store || do_load || win_out) st_d = fls_pkg::ST_IDLE;
         end
         fls_pkg::ST_BUSY:  if (done) st_d = fls_pkg::ST_IDLE;
         default:           st_d = fls_pkg::ST_IDLE;
      endcase
   end

   // write timer runs on system reset only so core resets cannot abort it
   fls_timer #(.CYCLES(WRITE_CYCLES)) u_timer (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .start   (start),
      .done    (done)
   );

   // command state: held through cpu reset while a write runs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q   <= fls_pkg::ST_IDLE;
         ctrl_q <= fls_pkg::CTRL_RESET;
         win_q  <= 3'h0;
         busy_q <= 1'b0;
         page_q <= 1'b0;
      end else if (cpu_rst && !busy) begin
         st_q   <= fls_pkg::ST_IDLE;
         ctrl_q <= fls_pkg::CTRL_RESET;
         win_q  <= 3'h0;
         busy_q <= busy_q;
         page_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         win_q  <= (st_d == fls_pkg::ST_ARMED && armed) ? win_q + 3'h1 : 3'h0;
         if (wr_arm && st_q == fls_pkg::ST_IDLE) ctrl_q <= ctrl_wdata;
         else begin
            if (st_d == fls_pkg::ST_IDLE) ctrl_q <= ctrl_q & ~fls_pkg::CMD_MASK;
            if (ctrl_wr && !busy)
               ctrl_q[fls_pkg::BIT_IRQ_EN] <= ctrl_wdata[fls_pkg::BIT_IRQ_EN];
         end
         if (pg_op && rww_target) busy_q <= 1'b1;
         else if (rww_re || pg_load) busy_q <= 1'b0;
         page_q <= start ? (pg_op && !rww_target) : (done ? 1'b0 : page_q);
      end
   end

   // lock bits and load data
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         lock_q <= fls_pkg::LOCK_RESET;
         ld_q   <= 8'h00;
         ldsp_q <= 1'b0;
      end else begin
         if (lock_wr)
            lock_q[fls_pkg::LOCK_BITS-1:0] <= lock_q[fls_pkg::LOCK_BITS-1:0]
                                              & r0_data[fls_pkg::LOCK_BITS-1:0];
         ld_q   <= do_load ? fls_sel(pointer, lock_q, fuse_low_byte, fuse_high_byte,
                                     fuse_extended_byte) : 8'h00;
         ldsp_q <= do_load;
      end
   end

   assign lock_bits        = lock_q;
   assign load_data        = ld_q;
   assign load_is_special  = ldsp_q;
   assign rww_read_blocked = busy_q;
   assign cpu_halt         = page_q;
   assign ctrl_rdata       = {ctrl_q[fls_pkg::BIT_IRQ_EN], busy_q, 1'b0,
                              ctrl_q[fls_pkg::BIT_RWW_RE:0]};

   AST_LOCK_WR_NO_HALT: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_wr |=> !cpu_halt) else $error("lock write halted cpu");
   AST_EE_BLOCK: assert property (@(posedge mclk) disable iff (sys_rst)
      ee_q |-> !start && !do_load) else $error("op during eeprom busy");
   AST_STORE_EN_HELD: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_wr |=> ctrl_rdata[fls_pkg::BIT_STORE_EN][*8]) else $error("store enable dropped");
   AST_WINDOW_CLOSE: assert property (@(posedge mclk) disable iff (sys_rst || cpu_rst)
      (armed && !store_strobe && !load_strobe)[*4] |=> !armed) else $error("window stayed open");
   AST_LOAD_DATA: assert property (@(posedge mclk) disable iff (sys_rst)
      do_load && pointer == fls_pkg::PTR_FUSE_HIGH |=> load_data == $past(fuse_high_byte))
      else $error("fuse high read wrong");
   AST_LOCK_AND: assert property (@(posedge mclk) disable iff (sys_rst)
      lock_wr |=> lock_bits[5:0] == ($past(lock_bits[5:0]) & $past(r0_data[5:0])))
      else $error("lock programming wrong");
   AST_EXT_HIGH: assert property (@(posedge mclk) disable iff (sys_rst)
      do_load && pointer == fls_pkg::PTR_FUSE_EXT |=> load_data[7:3] == 5'h1f)
      else $error("ext fuse upper bits");
   AST_RWW_BUSY: assert property (@(posedge mclk) disable iff (sys_rst)
      pg_op && rww_target |=> rww_read_blocked) else $error("rww busy not set");
   AST_HALT_NO_READ_WHILE_WRITE_SECTION: assert property (@(posedge mclk) disable iff (sys_rst || cpu_rst)
      pg_op && !rww_target |=> cpu_halt)
      else $error("no_read_while_write_section op did not halt");
   AST_RWW_REENABLE: assert property (@(posedge mclk) disable iff (sys_rst || cpu_rst)
      rww_re |=> !rww_read_blocked)
      else $error("rww busy not cleared");
   AST_LOCK_READ: assert property (@(posedge mclk) disable iff (sys_rst)
      do_load && pointer == fls_pkg::PTR_LOCK |=> load_data == $past(lock_bits))
      else $error("lock read wrong");
   AST_FUSE_LOW: assert property (@(posedge mclk) disable iff (sys_rst)
      do_load && pointer == fls_pkg::PTR_FUSE_LOW |=> load_data == $past(fuse_low_byte))
      else $error("fuse low read wrong");
   AST_PLAIN_LOAD: assert property (@(posedge mclk) disable iff (sys_rst)
      load_strobe && !do_load |=> !load_is_special && load_data == 8'h00)
      else $error("plain load flagged special");
   AST_READ_CLEARS_CMD: assert property (@(posedge mclk) disable iff (sys_rst)
      do_load && !start |=> !ctrl_rdata[fls_pkg::BIT_LOCK_SET]
                            && !ctrl_rdata[fls_pkg::BIT_STORE_EN])
      else $error("command bits kept after read");
   AST_EE_LOCK_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
      ee_q |=> $stable(lock_bits))
      else $error("lock bits changed during eeprom busy");
   AST_WRITE_END: assert property (@(posedge mclk) disable iff (sys_rst)
      busy && done |=> !ctrl_rdata[fls_pkg::BIT_STORE_EN])
      else $error("store enable kept after write");
endmodule
`default_nettype wire

//--- testbench/fls_cpu_model.sv
// cpu core model: timed control writes, store and load strobes
// assumes the sequencer samples its inputs on the rising edge of mclk
`timescale 1ns/10ps
`default_nettype none
module fls_cpu_model (
   // clock
   input  wire logic        mclk,
   // instruction side
   output logic             ctrl_wr,
   output logic [7:0]       ctrl_wdata,
   output logic             store_strobe,
   output logic             load_strobe,
   output logic [15:0]      pointer,
   output logic [7:0]       r0_data
);
   initial begin
      ctrl_wr = 1'b0;
      ctrl_wdata = 8'h00;
      store_strobe = 1'b0;
      load_strobe = 1'b0;
      pointer = 16'h0000;
      r0_data = 8'hff;
   end
   // control write, gap idle cycles, then one strobe; interrupts assumed masked
   task automatic run(input logic [7:0] cmd, input logic [15:0] ptr,
                      input logic [7:0] r0, input bit ld, input int gap);
      @(posedge mclk);
      #1;
      pointer = ptr;
      r0_data = r0;
      ctrl_wr = 1'b1;
      ctrl_wdata = cmd;
      @(posedge mclk);
      #1;
      ctrl_wr = 1'b0;
      repeat (gap) @(posedge mclk);
      #1;
      if (ld) load_strobe = 1'b1;
      else store_strobe = 1'b1;
      @(posedge mclk);
      #1;
      load_strobe = 1'b0;
      store_strobe = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the lock/fuse self-access sequencer
// assumes fls_seq and fls_cpu_model; short write time parameter
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int WC = 20;
   typedef struct {logic [15:0] ptr; logic [7:0] exp; int gap;} fls_row_s;
   logic mclk = 1'b0, sys_rst = 1'b1, cpu_rst = 1'b0, ee_busy = 1'b0, rww_tgt = 1'b0;
   logic ctrl_wr, store_strobe, load_strobe, load_is_special, rww_read_blocked, cpu_halt;
   logic [7:0] ctrl_wdata, r0_data, ctrl_rdata, load_data, lock_bits;
   logic [15:0] pointer;
   int miscompares = 0, cmp_count = 0, cyc = 0, n;
   fls_row_s rows [4] = '{'{16'h0000, 8'ha6, 0}, '{16'h0001, 8'hff, 2},
                          '{16'h0002, 8'hfd, 1}, '{16'h0003, 8'h3c, 0}};
   always #5 mclk = ~mclk;
   fls_cpu_model cpu (.mclk(mclk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
      .store_strobe(store_strobe), .load_strobe(load_strobe), .pointer(pointer),
      .r0_data(r0_data));
   fls_seq #(.WRITE_CYCLES(WC)) dut (.mclk(mclk), .sys_rst(sys_rst), .cpu_rst(cpu_rst),
      .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
      .store_strobe(store_strobe), .load_strobe(load_strobe), .pointer(pointer),
      .r0_data(r0_data), .rww_target(rww_tgt), .load_data(load_data),
      .load_is_special(load_is_special), .eeprom_write_busy(ee_busy),
      .fuse_low_byte(8'ha6), .fuse_high_byte(8'h3c), .fuse_extended_byte(3'h5),
      .lock_bits(lock_bits), .rww_read_blocked(rww_read_blocked), .cpu_halt(cpu_halt));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // special read; the registered answer stands only in the cycle after the load
   task automatic rd(input logic [15:0] ptr, input logic spec, input logic [7:0] exp, input int gap);
      cpu.run(8'h09, ptr, 8'hff, 1'b1, gap);
      check({7'h00, load_is_special}, {7'h00, spec}, "special flag");
      check(load_data, exp, "read value");
      check(ctrl_rdata & 8'h09, 8'h00, "command bits left set");
   endtask
   // poll store enable clear with a bound
   task automatic wait_idle;
      n = 0;
      while (ctrl_rdata[0] !== 1'b0 && n < 200) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      #1;
      sys_rst = 1'b0;
      check(ctrl_rdata, 8'h00, "ctrl reset");
      check(lock_bits, 8'hff, "lock reset");
      $display("reset test done");
      foreach (rows[i]) rd(rows[i].ptr, 1'b1, rows[i].exp, rows[i].gap);
      $display("table test done");
      rd(16'h0001, 1'b0, 8'h00, 3);
      cpu.run(8'h09, 16'h0001, 8'hc0, 1'b0, 4);
      repeat (2) @(posedge mclk);
      #1;
      check(lock_bits, 8'hff, "late store wrote");
      check(ctrl_rdata & 8'h09, 8'h00, "late store armed");
      $display("window test done");
      cpu.run(8'h09, 16'h0001, 8'hc5, 1'b0, 3);
      @(posedge mclk);
      #1;
      check(lock_bits, 8'hc5, "lock write");
      check({6'h00, rww_read_blocked, cpu_halt}, 8'h00, "read blocked");
      check(ctrl_rdata & 8'h09, 8'h09, "store enable dropped");
      repeat (4) @(posedge mclk);
      #1;
      cpu_rst = 1'b1;
      @(posedge mclk);
      #1;
      cpu_rst = 1'b0;
      check({7'h00, ctrl_rdata[0]}, 8'h01, "write aborted by reset");
      wait_idle();
      check(8'(n + 6), 8'(WC), "write length");
      rd(16'h0001, 1'b1, 8'hc5, 0);
      $display("lock write test done");
      ee_busy = 1'b1;
      repeat (3) @(posedge mclk);
      cpu.run(8'h09, 16'h0001, 8'hc0, 1'b0, 1);
      repeat (3) @(posedge mclk);
      #1;
      check(lock_bits, 8'hc5, "write during eeprom busy");
      rd(16'h0000, 1'b0, 8'h00, 0);
      ee_busy = 1'b0;
      $display("eeprom busy test done");
      repeat (3) @(posedge mclk);
      #1;
      rww_tgt = 1'b1;
      cpu.run(8'h03, 16'h0000, 8'hff, 1'b0, 0);
      check(ctrl_rdata, 8'h43, "rww erase status");
      check({6'h00, rww_read_blocked, cpu_halt}, 8'h02, "rww erase blocks");
      wait_idle();
      check(ctrl_rdata, 8'h40, "rww busy after erase");
      if (rww_read_blocked) cpu.run(8'h11, 16'h0000, 8'hff, 1'b0, 0);
      check({6'h00, rww_read_blocked, cpu_halt}, 8'h00, "rww re-enable");
      rww_tgt = 1'b0;
      cpu.run(8'h05, 16'h0000, 8'hff, 1'b0, 1);
      check({6'h00, rww_read_blocked, cpu_halt}, 8'h01, "no_read_while_write_section write halts");
      wait_idle();
      check({7'h00, cpu_halt}, 8'h00, "halt released");
      cpu.run(8'h80, 16'h0000, 8'hff, 1'b1, 0);
      check(ctrl_rdata, 8'h80, "irq enable bit");
      $display("page op test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
